// ---- sss_host.sv ----
// host processor model: watchdog kicks and chip-select activity
`timescale 1ns/1ns
`default_nettype none
module sss_host (
	// clock and control
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic kick_en_i,
	// lines toward the supervisor
	output logic      wd_kick_in_o,
	output logic      ce_in_n_o
);
	logic [3:0] gap_r = 4'h0;
	initial
	begin
		wd_kick_in_o = 1'b0;
		ce_in_n_o = 1'b1;
	end
	always @(posedge clk_i)
	begin
		gap_r <= gap_r + 4'h1;
		if (kick_en_i && reset_n_i && gap_r == 4'hf)
			wd_kick_in_o <= !wd_kick_in_o;
		ce_in_n_o <= gap_r[3] | !reset_n_i;
	end
endmodule
`default_nettype wire

// ---- sss_pkg.sv ----
// constants and types for the supply supervisor with reset and watchdog
package sss_pkg;
	// clock
	localparam int unsigned CLK_PERIOD_NS = 20;
	// timing figures in their own units
	localparam int unsigned MR_DELAY_NS    = 12000;
	localparam int unsigned CE_HOLD_NS     = 15000;
	localparam int unsigned STRETCH_MS     = 200;
	localparam int unsigned WD_TIMEOUT_MS  = 1600;
	localparam int unsigned WD_PULSE_US    = 1700;
	// derived cycle counts
	localparam int unsigned MR_DELAY_CYC =
		(MR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CE_HOLD_CYC = CE_HOLD_NS / CLK_PERIOD_NS;
	localparam int unsigned STRETCH_CYC =
		(STRETCH_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned WD_TIMEOUT_CYC =
		(WD_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned WD_PULSE_CYC =
		(WD_PULSE_US * 1000) / CLK_PERIOD_NS;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	// ctrl fields and reset value
	localparam int unsigned CTRL_FORCE_RST_BIT = 0;
	localparam logic        CTRL_RESET_VAL     = 1'b0;
	// positions in the synchronised input vector
	localparam int unsigned IN_SUPPLY_OK   = 0;
	localparam int unsigned IN_LOWLINE_INT = 1;
	localparam int unsigned IN_MODE_EXT    = 2;
	localparam int unsigned IN_RESET_SENSE = 3;
	localparam int unsigned IN_LOWLINE_EXT = 4;
	localparam int unsigned IN_MR_N        = 5;
	localparam int unsigned IN_OVERVOLT    = 6;
	localparam int unsigned IN_KICK        = 7;
	localparam int unsigned IN_CE_N        = 8;
	localparam int unsigned IN_W           = 9;
	// reset sequencer states, gray along run -> hold -> stretch
	typedef enum logic [1:0] {
		SSS_RUN     = 2'b00,
		SSS_HOLD    = 2'b01,
		SSS_STRETCH = 2'b11
	} sss_state_t;
	// status word layout, low bits of the read data
	typedef struct packed {
		logic       mr_trip;
		logic       mode_ext;
		logic       wd_pulse_n;
		logic       wd_fault_n;
		logic       overvolt_flag_n;
		logic       lowline_n;
		logic       rst_active;
		sss_state_t state;
	} sss_status_t;
endpackage

// ---- sss_props.sv ----
// assertion checker for the supervisor outputs
`timescale 1ns/1ns
`default_nettype none
module sss_chk #(
	parameter int unsigned WD_TIMEOUT_CYC = sss_pkg::WD_TIMEOUT_CYC,
	parameter int unsigned WD_PULSE_CYC   = sss_pkg::WD_PULSE_CYC
) (
	// clock, reset and inputs
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic supply_ok_i,
	input wire logic mode_ext_i,
	input wire logic overvolt_sense_i,
	input wire logic wd_kick_in_i,
	// outputs watched
	input wire logic reset_n_o,
	input wire logic reset_o,
	input wire logic lowline_n_o,
	input wire logic overvolt_flag_n_o,
	input wire logic wd_fault_n_o,
	input wire logic wd_pulse_n_o
);
	logic [31:0] low_r, low_nxt, same_r, same_nxt;
	logic [3:0]  up_r, up_nxt;
	logic        kick_r;
	always_comb
	begin
		low_nxt = wd_pulse_n_o ? 32'h0 : low_r + 32'h1;
		same_nxt = (wd_kick_in_i != kick_r) ? 32'h0 : same_r + 32'h1;
		up_nxt = sys_rst_i ? 4'h0 : ((up_r == 4'hf) ? up_r : up_r + 4'h1);
	end
	always_ff @(posedge clk_i)
	begin
		low_r <= low_nxt;
		same_r <= same_nxt;
		up_r <= up_nxt;
		kick_r <= wd_kick_in_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	rst_pair_a: assert property (reset_o == !reset_n_o)
		else $error("reset pair differs");
	wd_held_a: assert property (reset_o && $past(reset_o) |-> wd_fault_n_o && wd_pulse_n_o)
		else $error("watchdog outputs low in reset");
	ov_follow_a: assert property ((up_r == 4'hf) ##0 $stable(overvolt_sense_i)[*4] |-> overvolt_flag_n_o == !overvolt_sense_i)
		else $error("overvoltage flag wrong");
	pulse_width_a: assert property ($rose(wd_pulse_n_o) && !reset_o && !$past(reset_o) |-> low_r == WD_PULSE_CYC)
		else $error("pulse width wrong");
	fault_after_a: assert property ($fell(wd_pulse_n_o) && wd_fault_n_o && !reset_o |=> !wd_fault_n_o || reset_o)
		else $error("fault did not follow pulse");
	wd_timeout_a: assert property ($fell(wd_pulse_n_o) |-> same_r >= WD_TIMEOUT_CYC)
		else $error("pulse before timeout");
	fault_hold_a: assert property ($stable(wd_kick_in_i)[*6] ##0 (!wd_fault_n_o && supply_ok_i && !reset_o) |=> !wd_fault_n_o || reset_o)
		else $error("fault cleared without kick");
	supply_low_a: assert property ((!mode_ext_i && !supply_ok_i) ##0 $stable(supply_ok_i)[*5] |-> reset_o && !lowline_n_o)
		else $error("supply low not flagged");
endmodule
bind sss_top sss_chk #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC), .WD_PULSE_CYC(WD_PULSE_CYC)) i_sss_chk (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
	.mode_ext_i(mode_ext_i), .overvolt_sense_i(overvolt_sense_i),
	.wd_kick_in_i(wd_kick_in_i), .reset_n_o(reset_n_o), .reset_o(reset_o),
	.lowline_n_o(lowline_n_o), .overvolt_flag_n_o(overvolt_flag_n_o),
	.wd_fault_n_o(wd_fault_n_o), .wd_pulse_n_o(wd_pulse_n_o));
`default_nettype wire

// ---- sss_top.sv ----
// supply supervisor: reset sequencer, low-line, overvoltage, watchdog, ce gate
// Contract
// - manual reset low 25us surely resets
// - reset follows manual low after 12us
// - reset held while manual low; stretch after
// - reset on supply low or manual trip
// - hold reset 200ms after last cause
// - reset clears watchdog, forces outputs high
// - reset closes chip-select gate, output high
// - reset_o is exact complement of reset_n_o
// - mode-select comparator picks external thresholds
// - external mode uses external comparator results
// - internal low-line comes from internal comparator
// - internal low-line asserts no later than reset
// - overvoltage flag low while sense high only
// - kick stuck past timeout asserts watchdog outputs
// - fault stays low until next kick edge
// - pulse low 1.7ms, falls before fault
// - supply below threshold disables watchdog
// - any kick edge restarts watchdog timer
`timescale 1ns/1ns
`default_nettype none
module sss_top #(
	parameter int unsigned STRETCH_CYC    = sss_pkg::STRETCH_CYC,
	parameter int unsigned WD_TIMEOUT_CYC = sss_pkg::WD_TIMEOUT_CYC,
	parameter int unsigned WD_PULSE_CYC   = sss_pkg::WD_PULSE_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// comparator results and pins, asynchronous
	input  wire logic        supply_ok_i,
	input  wire logic        lowline_int_ok_i,
	input  wire logic        mode_ext_i,
	input  wire logic        reset_sense_ok_i,
	input  wire logic        lowline_sense_in_i,
	input  wire logic        manual_reset_n_i,
	input  wire logic        overvolt_sense_i,
	input  wire logic        wd_kick_in_i,
	input  wire logic        ce_in_n_i,
	// supervisor outputs
	output logic             reset_n_o,
	output logic             reset_o,
	output logic             lowline_n_o,
	output logic             overvolt_flag_n_o,
	output logic             wd_fault_n_o,
	output logic             wd_pulse_n_o,
	output logic             ce_out_n_o,
	output logic             ce_in_hiz_o,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	// synchronisers
	logic [sss_pkg::IN_W-1:0] sync1_r;
	logic [sss_pkg::IN_W-1:0] sync2_r;
	logic [sss_pkg::IN_W-1:0] raw_in;

	assign raw_in = {ce_in_n_i, wd_kick_in_i, overvolt_sense_i,
		manual_reset_n_i, lowline_sense_in_i, reset_sense_ok_i,
		mode_ext_i, lowline_int_ok_i, supply_ok_i};

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			sync1_r <= '1;
			sync2_r <= '1;
		end
		else
		begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	logic supply_ok_s;
	logic lowline_int_s;
	logic mode_ext_s;
	logic reset_sense_s;
	logic lowline_ext_s;
	logic mr_n_s;
	logic overvolt_s;
	logic kick_s;
	logic ce_in_n_s;

	assign supply_ok_s   = sync2_r[sss_pkg::IN_SUPPLY_OK];
	assign lowline_int_s = sync2_r[sss_pkg::IN_LOWLINE_INT];
	assign mode_ext_s    = sync2_r[sss_pkg::IN_MODE_EXT];
	assign reset_sense_s = sync2_r[sss_pkg::IN_RESET_SENSE];
	assign lowline_ext_s = sync2_r[sss_pkg::IN_LOWLINE_EXT];
	assign mr_n_s        = sync2_r[sss_pkg::IN_MR_N];
	assign overvolt_s    = sync2_r[sss_pkg::IN_OVERVOLT];
	assign kick_s        = sync2_r[sss_pkg::IN_KICK];
	assign ce_in_n_s     = sync2_r[sss_pkg::IN_CE_N];

	// supply decision and flags
	logic supply_low;
	logic lowline_n_r;
	logic lowline_n_nxt;
	logic ovo_n_r;
	logic ovo_n_nxt;

	always_comb
	begin
		supply_low = mode_ext_s ? !reset_sense_s : !supply_ok_s;
		if (mode_ext_s)
			lowline_n_nxt = lowline_ext_s;
		else
			lowline_n_nxt = lowline_int_s && supply_ok_s;
		ovo_n_nxt = !overvolt_s;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			lowline_n_r <= 1'b0;
			ovo_n_r     <= 1'b1;
		end
		else
		begin
			lowline_n_r <= lowline_n_nxt;
			ovo_n_r     <= ovo_n_nxt;
		end
	end

	// manual reset delay filter
	logic [31:0] mr_cnt_r;
	logic [31:0] mr_cnt_nxt;
	logic        mr_trip_r;
	logic        mr_trip_nxt;

	always_comb
	begin
		mr_cnt_nxt  = 32'h0;
		mr_trip_nxt = 1'b0;
		if (!mr_n_s)
		begin
			if (mr_trip_r || mr_cnt_r == 32'(sss_pkg::MR_DELAY_CYC - 1))
				mr_trip_nxt = 1'b1;
			else
				mr_cnt_nxt = mr_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			mr_cnt_r  <= 32'h0;
			mr_trip_r <= 1'b0;
		end
		else
		begin
			mr_cnt_r  <= mr_cnt_nxt;
			mr_trip_r <= mr_trip_nxt;
		end
	end

	// reset sequencer
	sss_pkg::sss_state_t state_r;
	sss_pkg::sss_state_t state_nxt;
	logic [31:0]         str_cnt_r;
	logic [31:0]         str_cnt_nxt;
	logic                rst_active_r;
	logic                ctrl_force_r;
	logic                cause;

	always_comb
	begin
		cause       = supply_low || mr_trip_r || ctrl_force_r;
		state_nxt   = state_r;
		str_cnt_nxt = 32'h0;
		case (state_r)
			sss_pkg::SSS_RUN:
			begin
				if (cause)
					state_nxt = sss_pkg::SSS_HOLD;
			end
			sss_pkg::SSS_HOLD:
			begin
				if (!cause)
					state_nxt = sss_pkg::SSS_STRETCH;
			end
			sss_pkg::SSS_STRETCH:
			begin
				if (cause)
					state_nxt = sss_pkg::SSS_HOLD;
				else if (str_cnt_r == 32'(STRETCH_CYC - 1))
					state_nxt = sss_pkg::SSS_RUN;
				else
					str_cnt_nxt = str_cnt_r + 32'h1;
			end
			default:
				state_nxt = sss_pkg::SSS_HOLD;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r      <= sss_pkg::SSS_HOLD;
			str_cnt_r    <= 32'h0;
			rst_active_r <= 1'b1;
		end
		else
		begin
			state_r      <= state_nxt;
			str_cnt_r    <= str_cnt_nxt;
			rst_active_r <= (state_nxt != sss_pkg::SSS_RUN);
		end
	end

	// watchdog
	logic        kick_d_r;
	logic        kick_edge;
	logic [31:0] wd_cnt_r;
	logic [31:0] wd_cnt_nxt;
	logic [31:0] wp_cnt_r;
	logic [31:0] wp_cnt_nxt;
	logic        wd_fault_n_r;
	logic        wd_fault_n_nxt;
	logic        wd_pulse_n_r;
	logic        wd_pulse_n_nxt;
	logic        fault_pend_r;
	logic        fault_pend_nxt;

	always_comb
	begin
		kick_edge      = kick_s ^ kick_d_r;
		wd_cnt_nxt     = wd_cnt_r + 32'h1;
		wp_cnt_nxt     = wp_cnt_r;
		wd_fault_n_nxt = wd_fault_n_r;
		wd_pulse_n_nxt = wd_pulse_n_r;
		fault_pend_nxt = 1'b0;
		if (!wd_pulse_n_r)
		begin
			if (wp_cnt_r == 32'(WD_PULSE_CYC - 1))
				wd_pulse_n_nxt = 1'b1;
			else
				wp_cnt_nxt = wp_cnt_r + 32'h1;
		end
		// fault falls one cycle after pulse
		if (fault_pend_r)
			wd_fault_n_nxt = 1'b0;
		if (rst_active_r)
		begin
			wd_cnt_nxt     = 32'h0;
			wp_cnt_nxt     = 32'h0;
			wd_fault_n_nxt = 1'b1;
			wd_pulse_n_nxt = 1'b1;
			fault_pend_nxt = 1'b0;
		end
		else if (kick_edge)
		begin
			// edge restarts, fault clears
			// a pending fault still lands: set wins over clear
			wd_cnt_nxt     = 32'h0;
			wd_fault_n_nxt = !fault_pend_r;
			fault_pend_nxt = 1'b0;
		end
		else if (wd_cnt_r == 32'(WD_TIMEOUT_CYC - 1))
		begin
			wd_cnt_nxt     = 32'h0;
			wp_cnt_nxt     = 32'h0;
			wd_pulse_n_nxt = 1'b0;
			fault_pend_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			kick_d_r     <= 1'b1;
			wd_cnt_r     <= 32'h0;
			wp_cnt_r     <= 32'h0;
			wd_fault_n_r <= 1'b1;
			wd_pulse_n_r <= 1'b1;
			fault_pend_r <= 1'b0;
		end
		else
		begin
			kick_d_r     <= kick_s;
			wd_cnt_r     <= wd_cnt_nxt;
			wp_cnt_r     <= wp_cnt_nxt;
			wd_fault_n_r <= wd_fault_n_nxt;
			wd_pulse_n_r <= wd_pulse_n_nxt;
			fault_pend_r <= fault_pend_nxt;
		end
	end

	// chip-select gate
	logic        gate_open_r;
	logic        gate_open_nxt;
	logic [31:0] ce_cnt_r;
	logic [31:0] ce_cnt_nxt;

	always_comb
	begin
		gate_open_nxt = 1'b1;
		ce_cnt_nxt    = 32'h0;
		if (rst_active_r)
		begin
			// close, but let a write in progress finish
			gate_open_nxt = gate_open_r && !ce_in_n_s &&
				(ce_cnt_r < 32'(sss_pkg::CE_HOLD_CYC - 1));
			ce_cnt_nxt    = ce_cnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			gate_open_r <= 1'b0;
			ce_cnt_r    <= 32'h0;
		end
		else
		begin
			gate_open_r <= gate_open_nxt;
			ce_cnt_r    <= ce_cnt_nxt;
		end
	end

	// apb registers
	logic        ctrl_force_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic        addr_ok;
	sss_pkg::sss_status_t status;

	always_comb
	begin
		addr_ok = (paddr_i == sss_pkg::REG_CTRL) ||
			(paddr_i == sss_pkg::REG_STATUS);
		status.mr_trip         = mr_trip_r;
		status.mode_ext        = mode_ext_s;
		status.wd_pulse_n      = wd_pulse_n_r;
		status.wd_fault_n      = wd_fault_n_r;
		status.overvolt_flag_n = ovo_n_r;
		status.lowline_n       = lowline_n_r;
		status.rst_active      = rst_active_r;
		status.state           = state_r;
		ctrl_force_nxt = ctrl_force_r;
		if (psel_i && penable_i && pwrite_i &&
			paddr_i == sss_pkg::REG_CTRL)
			ctrl_force_nxt = pwdata_i[sss_pkg::CTRL_FORCE_RST_BIT];
		prdata_nxt = prdata_r;
		// read data captured in the setup cycle
		if (psel_i && !penable_i)
		begin
			if (paddr_i == sss_pkg::REG_CTRL)
				prdata_nxt = {31'h0, ctrl_force_r};
			else if (paddr_i == sss_pkg::REG_STATUS)
				prdata_nxt = {23'h0, status};
			else
				prdata_nxt = 32'h0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_force_r <= sss_pkg::CTRL_RESET_VAL;
			prdata_r     <= 32'h0;
		end
		else
		begin
			ctrl_force_r <= ctrl_force_nxt;
			prdata_r     <= prdata_nxt;
		end
	end

	// outputs
	// complementary reset pair
	assign reset_o           = rst_active_r;
	assign reset_n_o         = !rst_active_r;
	assign lowline_n_o       = lowline_n_r;
	assign overvolt_flag_n_o = ovo_n_r;
	assign wd_fault_n_o      = wd_fault_n_r;
	assign wd_pulse_n_o      = wd_pulse_n_r;
	assign ce_out_n_o        = gate_open_r ? ce_in_n_s : 1'b1;
	assign ce_in_hiz_o       = !gate_open_r;
	assign prdata_o          = prdata_r;
	assign pready_o          = 1'b1;
	assign pslverr_o         = psel_i && penable_i && !addr_ok;
endmodule
`default_nettype wire

// ---- sss_top_tb.sv ----
// self-checking bench for the supply supervisor
`timescale 1ns/1ns
`default_nettype none
module sss_top_tb;
	logic        clk = 1'b0, rst = 1'b1, sup = 1'b1, llint = 1'b1;
	logic        mext = 1'b0, rsense = 1'b1, llsense = 1'b1, mrn = 1'b1;
	logic        ovs = 1'b0, ken = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        kick, cen, rn, r, lln, ovf, wdf, wdp, ceo, hiz, prdy, perr, e;
	int          bad_count = 0, checks_done = 0, cyc = 0, n;
	always #10 clk = !clk;
	sss_top #(.STRETCH_CYC(50), .WD_TIMEOUT_CYC(100), .WD_PULSE_CYC(10)) i_sss_top (
		.clk_i(clk), .sys_rst_i(rst), .supply_ok_i(sup), .lowline_int_ok_i(llint),
		.mode_ext_i(mext), .reset_sense_ok_i(rsense), .lowline_sense_in_i(llsense),
		.manual_reset_n_i(mrn), .overvolt_sense_i(ovs), .wd_kick_in_i(kick),
		.ce_in_n_i(cen), .reset_n_o(rn), .reset_o(r), .lowline_n_o(lln),
		.overvolt_flag_n_o(ovf), .wd_fault_n_o(wdf), .wd_pulse_n_o(wdp),
		.ce_out_n_o(ceo), .ce_in_hiz_o(hiz), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(prdy), .pslverr_o(perr));
	sss_host i_sss_host (.clk_i(clk), .reset_n_i(rn), .kick_en_i(ken),
		.wd_kick_in_o(kick), .ce_in_n_o(cen));
	function automatic logic flag_exp(input logic s);
		return !s;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x)
		begin
			bad_count++;
			$display("[ERR] %0t saw %h expected %h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		q = prdata;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_on(input bit wd, input logic v);
		n = 0;
		while ((wd ? wdf : r) !== v && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		chk(wd ? wdf : r, v);
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	initial
	begin
		void'($urandom(12296));
		tick(3);
		rst <= 1'b0;
		tick(40);
		chk(r, 1'b1);
		chk(rn, 1'b0);
		chk(wdf & wdp, 1'b1);
		wait_on(0, 1'b0);
		$display("test power-up done");
		apb(0, 8'h00, 32'h0);
		chk(q, 32'h0);
		apb(1, 8'h08, 32'h1);
		chk(e, 1'b1);
		apb(1, 8'h00, 32'h1);
		wait_on(0, 1'b1);
		apb(0, 8'h00, 32'h0);
		chk(q, 32'h1);
		apb(1, 8'h00, 32'h0);
		wait_on(0, 1'b0);
		$display("test registers done");
		// short low ignored, long low resets
		mrn <= 1'b0;
		tick(100 + $urandom % 400);
		mrn <= 1'b1;
		tick(10);
		chk(r, 1'b0);
		mrn <= 1'b0;
		tick(700 + $urandom % 200);
		chk(r, 1'b1);
		mrn <= 1'b1;
		tick(40);
		chk(r, 1'b1);
		wait_on(0, 1'b0);
		$display("test manual done");
		repeat (20)
		begin
			ovs <= 1'($urandom);
			tick(5);
			chk(ovf, flag_exp(ovs));
			chk(r, 1'b0);
		end
		$display("test overvoltage done");
		ken <= 1'b0;
		wait_on(1, 1'b0);
		ken <= 1'b1;
		tick(30);
		chk(wdf, 1'b1);
		$display("test watchdog done");
		sup <= 1'b0;
		llint <= 1'b0;
		tick(6);
		chk(lln, 1'b0);
		chk(r, 1'b1);
		tick(800);
		chk(hiz & ceo, 1'b1);
		sup <= 1'b1;
		llint <= 1'b1;
		wait_on(0, 1'b0);
		chk(lln, 1'b1);
		$display("test supply done");
		mext <= 1'b1;
		tick(5);
		sup <= 1'b0;
		llsense <= 1'b0;
		tick(8);
		chk(r, 1'b0);
		chk(lln, 1'b0);
		rsense <= 1'b0;
		wait_on(0, 1'b1);
		rsense <= 1'b1;
		llsense <= 1'b1;
		wait_on(0, 1'b0);
		$display("test external done");
		give_verdict();
	end
endmodule
`default_nettype wire
